// ===== src/crc_top.sv
// Register file and digital output logic for two comparators and the reference ladder.
// Assumes a classic Wishbone master, raw comparator results arriving unsynchronised,
// and a timer clock that is an ordinary input sampled on clk_i.
`timescale 1ns/100ps
module crc_top
	import crc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [NUM_CMP-1:0] cmp_raw_i,
	input wire logic timer_clk_i,
	input wire logic [7:0] port_i,
	output crc_ref_t ref_ctrl_o,
	output crc_ana_t [NUM_CMP-1:0] cmp_ana_o,
	output logic [NUM_CMP-1:0] cmp_result_synced_o,
	output logic [NUM_CMP-1:0] cmp_result_unsynced_o,
	output logic [NUM_CMP-1:0] cmp_pin_o,
	output logic [NUM_CMP-1:0] cmp_pin_oe_o,
	output logic [NUM_CMP-1:0] cmp_interrupt_flag_o,
	output logic timer_gate_o
);

	crc_state_t s_reg;
	crc_state_t s_next;

	// ==========================================
	// Next-state logic
	// Bus access, comparator result path and edge flags are all computed here.
	always_comb
	begin
		logic req;
		logic wr;
		logic tfall;
		logic [NUM_CMP-1:0] res_n;
		logic [NUM_CMP-1:0] rise;
		logic [NUM_CMP-1:0] fall;
		logic [NUM_CMP-1:0] fset;
		logic [NUM_CMP-1:0] fclr;
		logic [7:0] rd;
		req = 1'b0;
		wr = 1'b0;
		tfall = 1'b0;
		res_n = '0;
		rise = '0;
		fall = '0;
		fset = '0;
		fclr = '0;
		rd = 8'h00;
		s_next = s_reg;

		// A request is answered one cycle after it is seen; ack drops the cycle after.
		// Ack is masked into req so a master that keeps cyc high is not served twice.
		req = wb_cyc_i & wb_stb_i & ~s_reg.ack;
		wr = req & wb_we_i & wb_sel_i[0];
		s_next.ack = req;

		// Only the low byte lane carries data, so writes without sel[0] change nothing.
		if (wr)
		begin
			unique case (wb_adr_i)
				OFS_REF_CTRL:
				begin
					s_next.rcfg.en = wb_dat_i[REF_EN_BIT];
					s_next.rcfg.pin_oe = wb_dat_i[REF_OE_BIT];
					s_next.rcfg.src = wb_dat_i[REF_SRC_LSB +: 2];
				end
				OFS_REF_LEVEL: s_next.rcfg.level = wb_dat_i[REF_LVL_LSB +: 5];
				OFS_PIN_CTRL:
				begin
					s_next.pdir = wb_dat_i[PC_DIR_LSB +: NUM_CMP];
					s_next.gsel = wb_dat_i[PC_GATE_LSB +: 2];
				end
				OFS_ANALOG_SEL: s_next.pin_analog_select = wb_dat_i[7:0];
				OFS_INT_FLAG: fclr = wb_dat_i[NUM_CMP-1:0];
				default:
				begin
				end
			endcase
			for (int i = 0; i < NUM_CMP; i++)
			begin
				if (wb_adr_i == OFS_CMP1_A + 6'(8 * i))
				begin
					s_next.cfg[i].en = wb_dat_i[CA_EN_BIT];
					s_next.cfg[i].inv = wb_dat_i[CA_INV_BIT];
					s_next.cfg[i].speed = wb_dat_i[CA_SP_BIT];
					s_next.cfg[i].hyst = wb_dat_i[CA_HYS_BIT];
					s_next.cfg[i].sync = wb_dat_i[CA_SYNC_BIT];
				end
				if (wb_adr_i == OFS_CMP1_B + 6'(8 * i))
				begin
					s_next.cfg[i].intp = wb_dat_i[CB_INTP_BIT];
					s_next.cfg[i].intn = wb_dat_i[CB_INTN_BIT];
					s_next.cfg[i].pch = wb_dat_i[CB_PCH_LSB +: 2];
					s_next.cfg[i].nch = wb_dat_i[CB_NCH_LSB +: 3];
				end
			end
		end

		// Read multiplexer; unmapped addresses answer with zero.
		unique case (wb_adr_i)
			OFS_REF_CTRL:
			begin
				rd[REF_EN_BIT] = s_reg.rcfg.en;
				rd[REF_OE_BIT] = s_reg.rcfg.pin_oe;
				rd[REF_SRC_LSB +: 2] = s_reg.rcfg.src;
			end
			OFS_REF_LEVEL: rd[REF_LVL_LSB +: 5] = s_reg.rcfg.level;
			OFS_SHARED_OUT: rd[NUM_CMP-1:0] = s_reg.res;
			OFS_INT_FLAG: rd[NUM_CMP-1:0] = s_reg.flag;
			OFS_PIN_CTRL:
			begin
				rd[PC_DIR_LSB +: NUM_CMP] = s_reg.pdir;
				rd[PC_GATE_LSB +: 2] = s_reg.gsel;
			end
			OFS_ANALOG_SEL: rd = s_reg.pin_analog_select;
			OFS_PORT: rd = port_i & ~s_reg.pin_analog_select;
			default: rd = 8'h00;
		endcase
		for (int i = 0; i < NUM_CMP; i++)
		begin
			if (wb_adr_i == OFS_CMP1_A + 6'(8 * i))
			begin
				rd[CA_EN_BIT] = s_reg.cfg[i].en;
				rd[CA_RES_BIT] = s_reg.res[i];
				rd[CA_INV_BIT] = s_reg.cfg[i].inv;
				rd[CA_SP_BIT] = s_reg.cfg[i].speed;
				rd[CA_HYS_BIT] = s_reg.cfg[i].hyst;
				rd[CA_SYNC_BIT] = s_reg.cfg[i].sync;
			end
			if (wb_adr_i == OFS_CMP1_B + 6'(8 * i))
			begin
				rd[CB_INTP_BIT] = s_reg.cfg[i].intp;
				rd[CB_INTN_BIT] = s_reg.cfg[i].intn;
				rd[CB_PCH_LSB +: 2] = s_reg.cfg[i].pch;
				rd[CB_NCH_LSB +: 3] = s_reg.cfg[i].nch;
			end
		end
		// Read data is zero outside the ack cycle, so a stale word never leaks.
		s_next.dat = req ? {24'h00_0000, rd} : 32'h0000_0000;

		s_next.s1 = cmp_raw_i;
		s_next.s2 = s_reg.s1;

		// The timer clock is sampled like any input; a pulse shorter than a cycle can be missed.
		// timer clock falling edge
		tfall = s_reg.tclk_prev & ~timer_clk_i;
		s_next.tclk_prev = timer_clk_i;

		for (int i = 0; i < NUM_CMP; i++)
		begin
			// raw high means plus above minus
			// disabled comparator reads low before polarity
			res_n[i] = (s_reg.cfg[i].en & s_reg.s2[i]) ^ s_reg.cfg[i].inv;
			s_next.res[i] = res_n[i];
			s_next.res_prev[i] = s_reg.res[i];
			// Holding the copy between falls keeps the timer from seeing a change mid-count.
			// latch on timer fall in sync mode
			if (!s_reg.cfg[i].sync || tfall)
			begin
				s_next.sout[i] = s_reg.res[i];
			end
			rise[i] = s_reg.res[i] & ~s_reg.res_prev[i];
			fall[i] = ~s_reg.res[i] & s_reg.res_prev[i];
			fset[i] = (rise[i] & s_reg.cfg[i].intp) | (fall[i] & s_reg.cfg[i].intn);

			// Analog front-end controls leave through flops.
			// inputs off while disabled
			s_next.ana[i].inputs_on = s_reg.cfg[i].en;
			s_next.ana[i].pch = s_reg.cfg[i].pch;
			s_next.ana[i].nch = s_reg.cfg[i].nch;
			s_next.ana[i].speed = s_reg.cfg[i].speed;
			s_next.ana[i].hyst = s_reg.cfg[i].hyst;
			// Direction bit high means input, so the pin is released.
			// pin drive condition
			s_next.pin_oe[i] = ~s_reg.pdir[i] & s_reg.cfg[i].en;
		end
		// A flag raised by toggling polarity or enable is expected behaviour.
		// Set wins over a software clear arriving in the same cycle.
		s_next.flag = (s_reg.flag & ~fclr) | fset;

		unique case (s_reg.gsel)
			2'h1: s_next.gate = s_reg.sout[0];
			2'h2: s_next.gate = s_reg.sout[1];
			default: s_next.gate = 1'b0;
		endcase

		s_next.ref_out = s_reg.rcfg;

		// Synchronous reset overrides everything computed above.
		// Configuration and the speed output keep their documented reset values; everything else clears.
		if (rst_i)
		begin
			s_next = '0;
			for (int i = 0; i < NUM_CMP; i++)
			begin
				s_next.cfg[i].speed = SPEED_RESET;
				s_next.ana[i].speed = SPEED_RESET;
			end
			s_next.pdir = DIR_RESET;
			s_next.pin_analog_select = ANALOG_SEL_RESET;
			s_next.gsel = GATE_NONE;
		end
	end

	// ==========================================
	// State register
	always_ff @(posedge clk_i)
	begin
		s_reg <= s_next;
	end

	// ==========================================
	// Outputs, each taken straight from a state field
	assign wb_dat_o = s_reg.dat;
	assign wb_ack_o = s_reg.ack;
	assign ref_ctrl_o = s_reg.ref_out;
	assign cmp_ana_o = s_reg.ana;
	// synced copy to converter and timer
	assign cmp_result_synced_o = s_reg.sout;
	assign cmp_result_unsynced_o = s_reg.res;
	assign cmp_pin_o = s_reg.sout;
	assign cmp_pin_oe_o = s_reg.pin_oe;
	assign cmp_interrupt_flag_o = s_reg.flag;
	assign timer_gate_o = s_reg.gate;

	// ==========================================
	// Assertions and covers
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Bus handshake: one ack per request, gone again in the next cycle.
	bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("Bus ack did not follow request.");
	// Unused read lanes stay zero, so a wide read never picks up stray bits.
	upper_zero_a: assert property (wb_dat_o[31:8] == 24'h00_0000)
		else $error("Upper read lanes nonzero.");
	ref_reserved_a: assert property (wb_ack_o && $past(wb_adr_i) == OFS_REF_CTRL |->
		wb_dat_o[6] == 1'b0 && wb_dat_o[4] == 1'b0 && wb_dat_o[1:0] == 2'h0 && wb_dat_o[31:8] == 24'h00_0000)
		else $error("Reserved reference bits read nonzero.");
	level_reserved_a: assert property (wb_ack_o && $past(wb_adr_i) == OFS_REF_LEVEL |->
		wb_dat_o[7:5] == 3'h0)
		else $error("Reserved level bits read nonzero.");
	// The converter control leaves one cycle after the register write.
	ref_enable_a: assert property (wb_ack_o && $past(wb_we_i && wb_sel_i[0] && wb_adr_i == OFS_REF_CTRL) |=>
		ref_ctrl_o.en == $past(wb_dat_i[REF_EN_BIT], 2))
		else $error("Reference enable output wrong after write.");

	// Result path: the raw level passes two flops, then the capture register.
	sync_stage_a: assert property (s_reg.s2 == $past(cmp_raw_i, 2))
		else $error("Synchroniser depth is not two flops.");
	result_path_a: assert property (
		($stable(cmp_raw_i[0]) && $stable(s_reg.cfg[0]) && s_reg.cfg[0].en)[*4] |->
		cmp_result_unsynced_o[0] == (cmp_raw_i[0] ^ s_reg.cfg[0].inv))
		else $error("Captured result disagrees with raw input and polarity.");
	// A switched-off comparator reports only its polarity bit.
	result_off_a: assert property (!$past(s_reg.cfg[0].en) |->
		cmp_result_unsynced_o[0] == $past(s_reg.cfg[0].inv))
		else $error("Disabled comparator reports a compared level.");
	shared_mirror_a: assert property (wb_ack_o && $past(wb_adr_i) == OFS_SHARED_OUT |->
		wb_dat_o[NUM_CMP-1:0] == $past(cmp_result_unsynced_o))
		else $error("Shared output register disagrees with results.");

	// Analog front-end controls follow the registers one cycle later.
	inputs_off_a: assert property (cmp_ana_o[1].inputs_on |-> $past(s_reg.cfg[1].en))
		else $error("Inputs connected while comparator disabled.");
	speed_out_a: assert property (cmp_ana_o[1].speed == $past(s_reg.cfg[1].speed))
		else $error("Speed select output disagrees with register.");
	hyst_out_a: assert property (cmp_ana_o[0].hyst == $past(s_reg.cfg[0].hyst))
		else $error("Hysteresis output disagrees with register.");
	route_out_a: assert property (cmp_ana_o[1].pch == $past(s_reg.cfg[1].pch) &&
		cmp_ana_o[1].nch == $past(s_reg.cfg[1].nch))
		else $error("Channel routing output disagrees with register.");
	pin_drive_a: assert property (cmp_pin_oe_o[0] |-> $past(s_reg.cfg[0].en && !s_reg.pdir[0]))
		else $error("Pin driven without enable and output direction.");
	pin_off_a: assert property (!s_reg.cfg[1].en || s_reg.pdir[1] |=> !cmp_pin_oe_o[1])
		else $error("Pin still driven after disable or input direction.");
	speed_reset_a: assert property ($past(rst_i) |-> s_reg.cfg[0].speed && s_reg.cfg[1].speed)
		else $error("Speed select not one after reset.");

	// Synced copy: follows the capture register, or only on a timer clock fall in sync mode.
	sync_follow_a: assert property (!s_reg.cfg[0].sync |=>
		cmp_result_synced_o[0] == $past(cmp_result_unsynced_o[0]))
		else $error("Synced result does not follow result with sync off.");
	sync_edge_a: assert property (s_reg.cfg[0].sync && s_reg.tclk_prev && !timer_clk_i |=>
		cmp_result_synced_o[0] == $past(cmp_result_unsynced_o[0]))
		else $error("Synced result not latched on timer clock fall.");
	sync_hold_a: assert property (s_reg.cfg[0].sync && !(s_reg.tclk_prev && !timer_clk_i) |=> $stable(cmp_result_synced_o[0]))
		else $error("Synced result changed without timer clock fall.");

	// Edge flags are sticky until software writes a one to clear them.
	edge_flag_a: assert property (s_reg.cfg[0].intp && $rose(s_reg.res[0]) |=> cmp_interrupt_flag_o[0])
		else $error("Rising edge did not set flag.");
	flag_sticky_a: assert property (
		cmp_interrupt_flag_o[0] && !(wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o) |=>
		cmp_interrupt_flag_o[0])
		else $error("Flag dropped without a software write.");
	// Timer gate: nothing selected means the timer sees a closed gate.
	gate_off_a: assert property (s_reg.gsel == 2'h0 || s_reg.gsel == 2'h3 |=> !timer_gate_o)
		else $error("Timer gate open with no source selected.");
	gate_one_a: assert property (s_reg.gsel == 2'h1 |=>
		timer_gate_o == $past(cmp_result_synced_o[0]))
		else $error("Timer gate does not follow the first comparator.");
	// Analog-selected pins read zero whatever level sits on them.
	port_analog_a: assert property (wb_ack_o && $past(wb_adr_i) == OFS_PORT |->
		(wb_dat_o[7:0] & s_reg.pin_analog_select) == 8'h00)
		else $error("Analog pin read nonzero on port.");

	// Covers for the main scenarios.
	flag_set_c: cover property (s_reg.cfg[1].intn && $fell(s_reg.res[1]) ##1 cmp_interrupt_flag_o[1]);
	sync_latch_c: cover property (s_reg.cfg[0].sync && s_reg.tclk_prev && !timer_clk_i ##1 $changed(cmp_result_synced_o[0]));
	write_c: cover property (wb_cyc_i && wb_stb_i && wb_we_i ##1 wb_ack_o);
	gate_c: cover property (s_reg.gsel == 2'h1 ##1 $rose(timer_gate_o));
	sel_ignore_c: cover property (wb_cyc_i && wb_stb_i && wb_we_i && !wb_sel_i[0] ##1 wb_ack_o);

endmodule

// ===== src/crc_pkg.sv
// Constants and carrier types for the comparator and reference-ladder control.
// Assumes a classic Wishbone slave port with 32-bit data and byte addressing.
package crc_pkg;

	// ==========================================
	// Sizes and register map
	localparam int NUM_CMP = 2;
	localparam int ADDR_W = 6;
	localparam logic [5:0] OFS_REF_CTRL = 6'h00;
	localparam logic [5:0] OFS_REF_LEVEL = 6'h04;
	localparam logic [5:0] OFS_CMP1_A = 6'h08;
	localparam logic [5:0] OFS_CMP1_B = 6'h0C;
	localparam logic [5:0] OFS_CMP2_A = 6'h10;
	localparam logic [5:0] OFS_CMP2_B = 6'h14;
	localparam logic [5:0] OFS_SHARED_OUT = 6'h18;
	localparam logic [5:0] OFS_INT_FLAG = 6'h1C;
	localparam logic [5:0] OFS_PIN_CTRL = 6'h20;
	localparam logic [5:0] OFS_ANALOG_SEL = 6'h24;
	localparam logic [5:0] OFS_PORT = 6'h28;

	// ==========================================
	// Field positions
	localparam int REF_EN_BIT = 7;
	localparam int REF_OE_BIT = 5;
	localparam int REF_SRC_LSB = 2;
	localparam int REF_LVL_LSB = 0;
	localparam int CA_EN_BIT = 7;
	localparam int CA_RES_BIT = 6;
	localparam int CA_INV_BIT = 4;
	localparam int CA_SP_BIT = 2;
	localparam int CA_HYS_BIT = 1;
	localparam int CA_SYNC_BIT = 0;
	localparam int CB_INTP_BIT = 7;
	localparam int CB_INTN_BIT = 6;
	localparam int CB_PCH_LSB = 4;
	localparam int CB_NCH_LSB = 0;
	localparam int PC_DIR_LSB = 0;
	localparam int PC_GATE_LSB = 4;

	// ==========================================
	// Encodings and reset values
	localparam logic [1:0] SRC_SUPPLY = 2'h0;
	localparam logic [1:0] SRC_EXT_PIN = 2'h1;
	localparam logic [1:0] SRC_FIXED_REF = 2'h2;
	localparam logic [1:0] PCH_PIN = 2'h0;
	localparam logic [1:0] PCH_REF_CONV = 2'h1;
	localparam logic [1:0] PCH_FIXED_REF = 2'h2;
	localparam logic [1:0] PCH_GROUND = 2'h3;
	localparam logic [2:0] NCH_FIXED_REF = 3'h6;
	localparam logic [2:0] NCH_GROUND = 3'h7;
	localparam logic [1:0] GATE_NONE = 2'h0;
	localparam logic SPEED_RESET = 1'b1;
	localparam logic [1:0] DIR_RESET = 2'h3;
	localparam logic [7:0] ANALOG_SEL_RESET = 8'hFF;

	// ==========================================
	// Carrier types
	typedef struct packed {
		logic en;
		logic pin_oe;
		logic [1:0] src;
		logic [4:0] level;
	} crc_ref_t;

	typedef struct packed {
		logic en;
		logic inv;
		logic speed;
		logic hyst;
		logic sync;
		logic intp;
		logic intn;
		logic [1:0] pch;
		logic [2:0] nch;
	} crc_cfg_t;

	typedef struct packed {
		logic inputs_on;
		logic speed;
		logic hyst;
		logic [1:0] pch;
		logic [2:0] nch;
	} crc_ana_t;

	typedef struct packed {
		crc_ref_t rcfg;
		crc_cfg_t [NUM_CMP-1:0] cfg;
		logic [NUM_CMP-1:0] pdir;
		logic [1:0] gsel;
		logic [7:0] pin_analog_select;
		logic [NUM_CMP-1:0] s1;
		logic [NUM_CMP-1:0] s2;
		logic [NUM_CMP-1:0] res;
		logic [NUM_CMP-1:0] res_prev;
		logic [NUM_CMP-1:0] sout;
		logic [NUM_CMP-1:0] flag;
		logic tclk_prev;
		logic ack;
		logic [31:0] dat;
		crc_ref_t ref_out;
		crc_ana_t [NUM_CMP-1:0] ana;
		logic [NUM_CMP-1:0] pin_oe;
		logic gate;
	} crc_state_t;

endpackage

// ===== verif/crc_analog_model.sv
// Behavioural analog front end for both comparators, the far side of the block.
// Assumes the bench sets the plus and minus input levels as plain codes.
`timescale 1ns/100ps
module crc_analog_model
	import crc_pkg::*;
(
	input wire crc_ana_t [NUM_CMP-1:0] ana_i,
	input wire logic [NUM_CMP-1:0][7:0] vpos_i,
	input wire logic [NUM_CMP-1:0][7:0] vneg_i,
	output logic [NUM_CMP-1:0] raw_o
);
	// ==========================================
	// Comparison
	// A switched-off comparator draws no current, so its output rests low.
	// Only the ground codes are modelled; other channels use the bench levels.
	always_comb
	begin
		for (int i = 0; i < NUM_CMP; i++)
		begin
			raw_o[i] = ana_i[i].inputs_on && ((ana_i[i].pch == PCH_GROUND ? 8'h00 : vpos_i[i]) >
				(ana_i[i].nch == NCH_GROUND ? 8'h00 : vneg_i[i]));
		end
	end
endmodule

// ===== verif/tb.sv
// Self-checking bench for the comparator and reference-ladder control block.
// Assumes crc_pkg, crc_top and crc_analog_model are compiled before it.
`timescale 1ns/100ps
module tb
	import crc_pkg::*;
;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [5:0] adr = 6'h00;
	logic [31:0] dat_w = 32'h0000_0000;
	logic [3:0] sel = 4'hF;
	logic [31:0] dat_r;
	logic [31:0] q;
	logic ack;
	logic tclk = 1'b0;
	logic [7:0] port = 8'h00;
	logic [1:0][7:0] vp = 16'h0000;
	logic [1:0][7:0] vn = 16'h0000;
	logic [1:0] raw, syn, uns, pin, pin_oe, flag;
	logic gate;
	crc_ref_t refc;
	crc_ana_t [1:0] ana;
	int n_errors = 0;
	int check_count = 0;

	// ==========================================
	// Clock and instances
	// Free-running 100 MHz clock.
	always #5 clk_i = ~clk_i;

	crc_top crc_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
		.cmp_raw_i(raw), .timer_clk_i(tclk), .port_i(port), .ref_ctrl_o(refc), .cmp_ana_o(ana),
		.cmp_result_synced_o(syn), .cmp_result_unsynced_o(uns), .cmp_pin_o(pin), .cmp_pin_oe_o(pin_oe),
		.cmp_interrupt_flag_o(flag), .timer_gate_o(gate));

	crc_analog_model crc_analog_model_inst (.ana_i(ana), .vpos_i(vp), .vneg_i(vn), .raw_o(raw));

	// ==========================================
	// Shared tasks
	// Comparison with case equality, so an unknown never matches.
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task test_done;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Classic single cycle: the request stands until ack is seen at a rising edge,
	// read data is taken at that same edge, and only then is the request released.
	task wb(input logic w, input logic [5:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat_w <= {24'h00_0000, d};
		@(posedge clk_i);
		while (ack !== 1'b1 && n < 20)
		begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 20)
		begin
			n_errors++;
			test_done;
		end
		q = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task rdc(input string nm, input logic [5:0] a, input logic [7:0] e);
		wb(1'b0, a, 8'h00);
		chk(nm, {24'h00_0000, e}, q);
	endtask

	task wt(input int n);
		repeat (n) @(negedge clk_i);
	endtask

	// Sets the levels of comparator 1 and lets the result path settle.
	task lvl(input logic [7:0] p, input logic [7:0] m);
		@(posedge clk_i);
		vp[0] <= p;
		vn[0] <= m;
		wt(6);
	endtask

	task tpulse;
		@(posedge clk_i);
		tclk <= 1'b1;
		repeat (2) @(posedge clk_i);
		tclk <= 1'b0;
		wt(4);
	endtask

	// ==========================================
	// Scenarios
	task t_reset;
		rdc("ref_ctrl", OFS_REF_CTRL, 8'h00);
		rdc("ref_level", OFS_REF_LEVEL, 8'h00);
		rdc("cmp1_a", OFS_CMP1_A, 8'h04);
		rdc("cmp2_a", OFS_CMP2_A, 8'h04);
		chk("speed", 32'h0000_0001, {31'h0, ana[0].speed});
		$display("t_reset done");
	endtask

	// Every source code with all unimplemented bits written as one.
	task t_ref;
		for (int s = 0; s < 4; s++)
		begin
			wb(1'b1, OFS_REF_CTRL, 8'hF3 | 8'(s << 2));
			rdc("ref_ctrl", OFS_REF_CTRL, 8'hA0 | 8'(s << 2));
			wt(2);
			chk("ref_out", {23'h0, 9'h180 | 9'(s << 5)}, {23'h0, refc[8:5], 5'h00});
		end
		wb(1'b1, OFS_REF_LEVEL, 8'hEA);
		// A write without the low byte lane is acked but must leave the level alone.
		sel <= 4'h0;
		wb(1'b1, OFS_REF_LEVEL, 8'h15);
		sel <= 4'hF;
		rdc("ref_level", OFS_REF_LEVEL, 8'h0A);
		wb(1'b1, OFS_REF_CTRL, 8'h00);
		wt(2);
		chk("ref_out", 32'h0000_000A, {23'h0, refc});
		$display("t_ref done");
	endtask

	task t_cmp;
		wb(1'b1, OFS_CMP1_B, 8'h00);
		wb(1'b1, OFS_CMP1_A, 8'h84);
		lvl(8'h80, 8'h40);
		rdc("cmp1_a", OFS_CMP1_A, 8'hC4);
		rdc("shared", OFS_SHARED_OUT, 8'h01);
		chk("uns", 32'h0000_0001, {30'h0, uns});
		chk("syn", 32'h0000_0001, {30'h0, syn});
		rdc("cmp2_a", OFS_CMP2_A, 8'h04);
		chk("on", 32'h0000_0001, {30'h0, ana[1].inputs_on, ana[0].inputs_on});
		wb(1'b1, OFS_CMP1_A, 8'h94);
		wt(6);
		rdc("cmp1_inv", OFS_CMP1_A, 8'h94);
		lvl(8'h40, 8'h80);
		rdc("cmp1_swap", OFS_CMP1_A, 8'hD4);
		wb(1'b1, OFS_CMP1_A, 8'h02);
		wt(6);
		rdc("cmp1_off", OFS_CMP1_A, 8'h02);
		chk("ana0", 32'h0000_0020, {24'h0, ana[0]});
		$display("t_cmp done");
	endtask

	// Comparator 2 stays off, so its inputs must stay disconnected.
	task t_chan;
		for (int p = 0; p < 4; p++)
		begin
			wb(1'b1, OFS_CMP2_B, 8'(p << 4) | 8'h08 | 8'(p + 4));
			rdc("cmp2_b", OFS_CMP2_B, 8'(p << 4) | 8'(p + 4));
			wt(2);
			chk("ana1", {24'h0, 3'b010, 2'(p), 3'(p + 4)}, {24'h0, ana[1]});
		end
		$display("t_chan done");
	endtask

	task t_pin;
		wb(1'b1, OFS_CMP1_A, 8'h84);
		lvl(8'h80, 8'h40);
		wb(1'b1, OFS_PIN_CTRL, 8'h12);
		wt(3);
		chk("pin_oe", 32'h0000_0001, {30'h0, pin_oe});
		chk("pin", 32'h0000_0001, {31'h0, pin[0]});
		chk("gate", 32'h0000_0001, {31'h0, gate});
		wb(1'b1, OFS_CMP1_A, 8'h04);
		wt(6);
		chk("pin_oe_off", 32'h0000_0000, {30'h0, pin_oe});
		chk("gate_off", 32'h0000_0000, {31'h0, gate});
		@(posedge clk_i);
		port <= 8'hA5;
		wb(1'b1, OFS_ANALOG_SEL, 8'h0F);
		rdc("port", OFS_PORT, 8'hA0);
		$display("t_pin done");
	endtask

	// Sync mode is the way to gate the timer safely.
	task t_sync;
		wb(1'b1, OFS_CMP1_A, 8'h85);
		wt(4);
		tpulse;
		chk("syn_hi", 32'h0000_0001, {31'h0, syn[0]});
		chk("gate_sync", 32'h0000_0001, {31'h0, gate});
		lvl(8'h40, 8'h80);
		chk("uns_lo", 32'h0000_0000, {31'h0, uns[0]});
		chk("syn_held", 32'h0000_0001, {31'h0, syn[0]});
		chk("gate_held", 32'h0000_0001, {31'h0, gate});
		tpulse;
		chk("syn_lo", 32'h0000_0000, {31'h0, syn[0]});
		chk("gate_lo", 32'h0000_0000, {31'h0, gate});
		$display("t_sync done");
	endtask

	task t_flag;
		wb(1'b1, OFS_CMP1_A, 8'h84);
		wb(1'b1, OFS_CMP1_B, 8'h80);
		wb(1'b1, OFS_INT_FLAG, 8'h03);
		lvl(8'h80, 8'h40);
		chk("flag_rise", 32'h0000_0001, {30'h0, flag});
		wb(1'b1, OFS_INT_FLAG, 8'h01);
		lvl(8'h40, 8'h80);
		chk("flag_fall", 32'h0000_0000, {30'h0, flag});
		$display("t_flag done");
	endtask

	// ==========================================
	// Main sequence
	initial
	begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset;
		t_ref;
		t_cmp;
		t_chan;
		t_pin;
		t_sync;
		t_flag;
		test_done;
	end
endmodule
